// *** rtl/uic_ctrl.sv ***
// Interrupt enable, identification and FIFO control for one channel.
// Assumes the datapath decodes its own registers and supplies sources.
`timescale 1ns/1ns
`default_nettype none
module uic_ctrl #(
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Host register bus
    input wire uic_pkg::uic_bus_t bus,
    input wire logic divisor_access,
    output logic [7:0] rd_data_q,
    // Channel sources
    input wire uic_pkg::uic_src_t src,
    input wire logic bit_tick,
    input wire logic [3:0] char_bits,
    // Interrupt pin control
    input wire logic mode_68,
    input wire logic interrupt_select_input,
    input wire logic mcr_int_enable,
    output logic irq_q,
    output logic irq_oe_q,
    // FIFO control outputs
    output logic fifo_enable_q,
    output logic dma_mode_q,
    output logic rx_fifo_reset_q,
    output logic tx_fifo_reset_q,
    // DMA handshake pins
    output logic receive_ready_pin_n_q,
    output logic transmit_ready_pin_n_q
);

    // Register state
    logic [3:0] ier_q;        // Interrupt enables
    logic [1:0] trig_q;       // Trigger code
    logic [3:0] id_q;         // Reported source code
    logic ls_pend_q;          // Line status pending
    logic to_pend_q;          // Time-out pending
    logic tx_pend_q;          // Transmit-ready pending
    logic rhr_err_q;          // Previous error tag
    logic tx_empty_q;         // Previous transmit empty

    // Decoded accesses
    logic data_sel;
    logic wr_ier, wr_fcr, wr_thr;
    logic rd_ier, rd_isr, rd_rhr, rd_lsr, rd_msr;
    logic [4:0] trig_lvl;
    logic rx_src, tx_empty, ms_src, to_exp;
    logic [4:0] act;          // Enabled pending per source
    logic [3:0] code_d;
    logic id_live;

    // Source slots in act
    localparam int S_LS = 0;
    localparam int S_TO = 1;
    localparam int S_RX = 2;
    localparam int S_TX = 3;
    localparam int S_MS = 4;

    // Registers shown only while divisor access is off
    assign data_sel = bus.cs && !divisor_access;
    assign wr_ier = data_sel && bus.wr && bus.addr == uic_pkg::ADDR_IER;
    assign wr_fcr = data_sel && bus.wr && bus.addr == uic_pkg::ADDR_ISR;
    assign wr_thr = data_sel && bus.wr && bus.addr == uic_pkg::ADDR_RHR;
    assign rd_ier = data_sel && bus.rd && bus.addr == uic_pkg::ADDR_IER;
    assign rd_isr = data_sel && bus.rd && bus.addr == uic_pkg::ADDR_ISR;
    assign rd_rhr = data_sel && bus.rd && bus.addr == uic_pkg::ADDR_RHR;
    assign rd_lsr = data_sel && bus.rd && bus.addr == uic_pkg::ADDR_LSR;
    assign rd_msr = data_sel && bus.rd && bus.addr == uic_pkg::ADDR_MSR;

    // Trigger level lookup
    always_comb begin
        unique case (trig_q)
            2'h0: trig_lvl = uic_pkg::TRIG_L0;
            2'h1: trig_lvl = uic_pkg::TRIG_L1;
            2'h2: trig_lvl = uic_pkg::TRIG_L2;
            2'h3: trig_lvl = uic_pkg::TRIG_L3;
        endcase
    end

    // Level sources; receive holds until count falls below trigger
    assign rx_src = fifo_enable_q ? (src.rx_count >= trig_lvl)
                                  : src.rhr_full;
    assign tx_empty = fifo_enable_q ? (src.tx_count == 5'h00)
                                    : src.thr_empty;
    // Modem deltas clear at their source on a status read
    assign ms_src = |src.msr_delta;

    // Enabled pending sources
    assign act[S_LS] = ier_q[uic_pkg::IER_LS] && ls_pend_q;
    assign act[S_TO] = ier_q[uic_pkg::IER_RX] && to_pend_q;
    assign act[S_RX] = ier_q[uic_pkg::IER_RX] && rx_src;
    assign act[S_TX] = ier_q[uic_pkg::IER_TX] && tx_pend_q;
    assign act[S_MS] = ier_q[uic_pkg::IER_MS] && ms_src;

    // Is a given code still backed by its source
    function automatic logic code_live(logic [3:0] c, logic [4:0] a);
        logic r;
        r = 1'b0;
        unique case (c)
            uic_pkg::ID_LS: r = a[S_LS];
            uic_pkg::ID_TO: r = a[S_TO];
            uic_pkg::ID_RX: r = a[S_RX];
            uic_pkg::ID_TX: r = a[S_TX];
            uic_pkg::ID_MS: r = a[S_MS];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Priority encoder, line status highest
    always_comb begin
        if (act[S_LS]) begin
            code_d = uic_pkg::ID_LS;
        end else if (act[S_TO]) begin
            code_d = uic_pkg::ID_TO;
        end else if (act[S_RX]) begin
            code_d = uic_pkg::ID_RX;
        end else if (act[S_TX]) begin
            code_d = uic_pkg::ID_TX;
        end else if (act[S_MS]) begin
            code_d = uic_pkg::ID_MS;
        end else begin
            code_d = uic_pkg::ID_NONE;
        end
    end

    assign id_live = code_live(id_q, act);

    // Reported code holds until its source is serviced
    always_ff @(posedge clk) begin
        if (srst) begin
            id_q <= uic_pkg::ID_NONE;
        end else if (!id_live) begin
            id_q <= code_d;
        end
    end

    // Interrupt enables; reserved bits are never stored
    always_ff @(posedge clk) begin
        if (srst) begin
            ier_q <= uic_pkg::IER_RESET;
        end else if (wr_ier) begin
            ier_q <= bus.wdata[3:0];
        end
    end

    // FIFO control: everything but bit 0 needs bit 0 in the same write
    always_ff @(posedge clk) begin
        if (srst) begin
            fifo_enable_q <= 1'b0;
            dma_mode_q <= 1'b0;
            trig_q <= uic_pkg::TRIG_RESET;
        end else if (wr_fcr) begin
            fifo_enable_q <= bus.wdata[uic_pkg::FCR_EN];
            if (bus.wdata[uic_pkg::FCR_EN]) begin
                dma_mode_q <= bus.wdata[uic_pkg::FCR_DMA];
                trig_q <= bus.wdata[uic_pkg::FCR_TRIG +: 2];
            end
        end
    end

    // FIFO reset strobes last one cycle, so the bits read as cleared
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_fifo_reset_q <= 1'b0;
            tx_fifo_reset_q <= 1'b0;
        end else begin
            rx_fifo_reset_q <= wr_fcr && bus.wdata[uic_pkg::FCR_EN]
                && bus.wdata[uic_pkg::FCR_RXRST];
            tx_fifo_reset_q <= wr_fcr && bus.wdata[uic_pkg::FCR_EN]
                && bus.wdata[uic_pkg::FCR_TXRST];
        end
    end

    // Edge history for error tag and transmit empty
    always_ff @(posedge clk) begin
        if (srst) begin
            rhr_err_q <= 1'b0;
            tx_empty_q <= 1'b1;
        end else begin
            rhr_err_q <= src.rhr_err;
            tx_empty_q <= tx_empty;
        end
    end

    // Line status pending; a new event beats a same-cycle read
    always_ff @(posedge clk) begin
        if (srst) begin
            ls_pend_q <= 1'b0;
        end else if (src.overrun || (src.rhr_err && !rhr_err_q)) begin
            ls_pend_q <= 1'b1;
        end else if (rd_lsr) begin
            ls_pend_q <= 1'b0;
        end
    end

    // Time-out timer runs only with data waiting in FIFO mode
    uic_rx_timeout #(
        .CW(CW)
    ) u_timeout (
        .clk(clk),
        .srst(srst),
        .run(fifo_enable_q && src.rx_count != 5'h00),
        .restart(src.rx_char_in || rd_rhr),
        .bit_tick(bit_tick),
        .char_bits(char_bits),
        .expire_q(to_exp)
    );

    // Time-out pending until the holding register is read or FIFO mode is turned off
    always_ff @(posedge clk) begin
        if (srst) begin
            to_pend_q <= 1'b0;
        end else if (to_exp) begin
            to_pend_q <= 1'b1;
        end else if (rd_rhr || !fifo_enable_q) begin
            to_pend_q <= 1'b0;
        end
    end

    // Transmit ready: set on becoming empty or on enabling while empty
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_pend_q <= 1'b0;
        end else if ((tx_empty && !tx_empty_q) || (wr_ier && tx_empty
                && bus.wdata[uic_pkg::IER_TX] && !ier_q[uic_pkg::IER_TX]))
        begin
            tx_pend_q <= 1'b1;
        end else if (wr_thr || (rd_isr && id_q == uic_pkg::ID_TX)) begin
            tx_pend_q <= 1'b0;
        end
    end

    // Read data; addresses other than IER and ISR read 0; the write-only control shares the ISR address
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_q <= 8'h00;
        end else if (rd_ier) begin
            rd_data_q <= {4'h0, ier_q};
        end else if (rd_isr) begin
            rd_data_q <= {fifo_enable_q, fifo_enable_q, 2'h0, id_q};
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    // Interrupt pin and its enable; modem reads clear at the source
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_q <= 1'b0;
            irq_oe_q <= 1'b0;
        end else begin
            irq_q <= |act;
            irq_oe_q <= mode_68 || interrupt_select_input
                || mcr_int_enable;
        end
    end

    // DMA mode changes when the ready pins assert
    always_ff @(posedge clk) begin
        if (srst) begin
            receive_ready_pin_n_q <= 1'b1;
            transmit_ready_pin_n_q <= 1'b1;
        end else if (dma_mode_q && fifo_enable_q) begin
            receive_ready_pin_n_q <= !(rx_src || to_pend_q);
            transmit_ready_pin_n_q <= src.tx_count >= uic_pkg::FIFO_DEPTH;
        end else begin
            receive_ready_pin_n_q <= !(src.rhr_full
                || src.rx_count != 5'h00);
            transmit_ready_pin_n_q <= !tx_empty;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_ier_read;
        rd_ier;
    endsequence

    a_ier_reserved_zero: assert property (
        s_ier_read |=> rd_data_q[7:4] == 4'h0
    ) else $error("reserved enable bits not zero");

    a_isr_fifo_bits: assert property (
        rd_isr |=> rd_data_q[7:4] == {$past(fifo_enable_q),
            $past(fifo_enable_q), 2'h0}
    ) else $error("ident top bits wrong");

    a_isr_pending_bit: assert property (
        rd_isr && id_q != uic_pkg::ID_NONE |=> !rd_data_q[0]
    ) else $error("pending not shown in bit 0");

    a_irq_follows: assert property (
        (|act) |=> irq_q
    ) else $error("interrupt not raised");

    a_irq_drops: assert property (
        !(|act) |=> !irq_q
    ) else $error("interrupt held without source");

    a_id_held: assert property (
        id_live |=> $stable(id_q)
    ) else $error("reported source changed while live");

    a_rx_reset_pulse: assert property (
        wr_fcr && bus.wdata[1:0] == 2'h3 ##1 !wr_fcr |=> !rx_fifo_reset_q
    ) else $error("receive reset did not self clear");

    a_fcr_gate: assert property (
        wr_fcr && !bus.wdata[uic_pkg::FCR_EN] |=> !fifo_enable_q
            && $stable(dma_mode_q) && $stable(trig_q)
            && !rx_fifo_reset_q && !tx_fifo_reset_q
    ) else $error("control bits taken without enable");

    a_ls_clear: assert property (
        rd_lsr && !src.overrun && !(src.rhr_err && !rhr_err_q)
            |=> !ls_pend_q
    ) else $error("line status read did not clear");

    a_tx_enable_fires: assert property (
        wr_ier && tx_empty && bus.wdata[1] && !ier_q[1] |=> ##1 irq_q
    ) else $error("enabling while empty gave no interrupt");

    a_oe_rule: assert property (
        !mode_68 && !interrupt_select_input && !mcr_int_enable
            |=> !irq_oe_q
    ) else $error("interrupt pin driven while disabled");

endmodule
`default_nettype wire

// *** rtl/uic_pkg.sv ***
// Constants, field layout and carriers for the UART interrupt/FIFO control.
// Assumes one 250 MHz clock and a synchronous, active-high reset.
package uic_pkg;

    // Register addresses on A2..A0
    localparam logic [2:0] ADDR_RHR = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;

    // Interrupt enable field positions and reset
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam logic [3:0] IER_RESET = 4'h0;

    // FIFO control field positions
    localparam int FCR_EN = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam int FCR_DMA = 3;
    localparam int FCR_TRIG = 6;
    localparam logic [1:0] TRIG_RESET = 2'h0;

    // Identification codes, priority 1 to 5, then none
    localparam logic [3:0] ID_LS = 4'h6;
    localparam logic [3:0] ID_TO = 4'hC;
    localparam logic [3:0] ID_RX = 4'h4;
    localparam logic [3:0] ID_TX = 4'h2;
    localparam logic [3:0] ID_MS = 4'h0;
    localparam logic [3:0] ID_NONE = 4'h1;

    // Receive trigger levels for codes 00..11
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;

    // Time-out length: characters plus extra bit times
    localparam logic [6:0] TO_CHARS = 7'h04;
    localparam logic [6:0] TO_EXTRA_BITS = 7'h0C;

    // FIFO depth in characters
    localparam logic [4:0] FIFO_DEPTH = 5'h10;

    // Host bus request, one cycle per strobe
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uic_bus_t;

    // Interrupt sources from the channel datapath
    typedef struct packed {
        logic rhr_full;
        logic [4:0] rx_count;
        logic rx_char_in;
        logic rhr_err;
        logic overrun;
        logic thr_empty;
        logic [4:0] tx_count;
        logic [3:0] msr_delta;
    } uic_src_t;

endpackage

// *** rtl/uic_rx_timeout.sv ***
// Receive time-out timer counting bit-time enables.
// Assumes bit_tick is a one-cycle enable at the bit rate.
`timescale 1ns/1ns
`default_nettype none
module uic_rx_timeout #(
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic bit_tick,
    input wire logic [3:0] char_bits,
    // Result
    output logic expire_q
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] limit;
    logic done_q;

    // Four frames plus twelve bit times
    assign limit = CW'(uic_pkg::TO_CHARS * {3'h0, char_bits}
        + uic_pkg::TO_EXTRA_BITS);

    // Counter restarts on any receive activity; stops once expired
    always_ff @(posedge clk) begin
        if (srst || restart || !run) begin
            cnt_q <= '0;
            done_q <= 1'b0;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            if (bit_tick && !done_q) begin
                if (cnt_q == limit - CW'(1)) begin
                    done_q <= 1'b1;
                    expire_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_expire_at_limit: assert property (
        expire_q |-> $past(cnt_q) == limit - CW'(1)
    ) else $error("time-out fired before limit");

endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the interrupt and FIFO control block.
// Assumes the host model owns the bus; channel sources are driven here.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // Clock, reset and channel stimulus
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic bit_tick = 1'b0;
    logic [3:0] char_bits = 4'hA;
    logic int_sel = 1'b0;
    logic mcr_ie = 1'b0;
    uic_pkg::uic_src_t src = '0;
    // Bus and block outputs
    uic_pkg::uic_bus_t bus;
    logic div_acc;
    logic [7:0] rd_data_q;
    logic irq_q, irq_oe_q, fifo_en, dma, rx_rst, tx_rst, rx_pin_n, tx_pin_n;
    // Bookkeeping
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] q;
    logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

    // 4 ns clock
    always #2 clk = ~clk;

    uic_host_model host (.clk(clk), .bus(bus), .divisor_access(div_acc),
        .rd_data_q(rd_data_q));

    // Pin mode tied to the non-68 bus
    uic_ctrl uut (.clk(clk), .srst(srst), .bus(bus),
        .divisor_access(div_acc), .rd_data_q(rd_data_q), .src(src),
        .bit_tick(bit_tick), .char_bits(char_bits), .mode_68(1'b0),
        .interrupt_select_input(int_sel), .mcr_int_enable(mcr_ie),
        .irq_q(irq_q), .irq_oe_q(irq_oe_q), .fifo_enable_q(fifo_en),
        .dma_mode_q(dma), .rx_fifo_reset_q(rx_rst),
        .tx_fifo_reset_q(tx_rst), .receive_ready_pin_n_q(rx_pin_n),
        .transmit_ready_pin_n_q(tx_pin_n));

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Step past n edges, landing off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask

    // Bounded wait on the interrupt level; a hang ends the run
    task automatic wait_irq(input logic e);
        int i;
        for (i = 0; i < 8 && irq_q !== e; i++) tick(1);
        chk({7'h0, irq_q}, {7'h0, e});
        if (irq_q !== e) test_done();
    endtask

    // Reset values and reserved enable bits
    task automatic s_reset();
        rd(uic_pkg::ADDR_ISR, 8'h01);
        rd(uic_pkg::ADDR_IER, 8'h00);
        wr(uic_pkg::ADDR_IER, 8'hFF);
        rd(uic_pkg::ADDR_IER, 8'h0F);
        wr(uic_pkg::ADDR_IER, 8'h00);
        rd(3'h7, 8'h00);
    endtask

    // Transmit-ready: fires on enable while empty, two ways to clear
    task automatic s_tx();
        src.thr_empty = 1'b1;
        wr(uic_pkg::ADDR_IER, 8'h02);
        wait_irq(1'b1);
        rd(uic_pkg::ADDR_ISR, 8'h02);
        wait_irq(1'b0);
        src.thr_empty = 1'b0;
        tick(2);
        src.thr_empty = 1'b1;
        wait_irq(1'b1);
        wr(uic_pkg::ADDR_RHR, 8'h55);
        wait_irq(1'b0);
        wr(uic_pkg::ADDR_IER, 8'h00);
        src.thr_empty = 1'b0;
    endtask

    // Priority order with three sources pending at once
    task automatic s_prio();
        wr(uic_pkg::ADDR_IER, 8'h0F);
        // Overrun first so line status is latched before the others
        src.overrun = 1'b1;
        tick(1);
        src.overrun = 1'b0;
        src.msr_delta = 4'h1;
        src.rhr_full = 1'b1;
        tick(2);
        rd(uic_pkg::ADDR_ISR, 8'h06);
        rd(uic_pkg::ADDR_ISR, 8'h06);
        rd(uic_pkg::ADDR_LSR, 8'h00);
        rd(uic_pkg::ADDR_ISR, 8'h04);
        src.rhr_full = 1'b0;
        tick(2);
        rd(uic_pkg::ADDR_ISR, 8'h00);
        rd(uic_pkg::ADDR_MSR, 8'h00);
        src.msr_delta = 4'h0;
        wait_irq(1'b0);
        // Errored character: the flag stays up after the status read
        src.rhr_err = 1'b1;
        wait_irq(1'b1);
        rd(uic_pkg::ADDR_ISR, 8'h06);
        rd(uic_pkg::ADDR_LSR, 8'h00);
        wait_irq(1'b0);
        src.rhr_err = 1'b0;
        wr(uic_pkg::ADDR_IER, 8'h00);
    endtask

    // Enable, self-clearing resets, DMA pin, refused control write
    task automatic s_fifo();
        host.fifo_ctl(8'h02, q);
        chk({6'h0, fifo_en, rx_rst}, 8'h03);
        tick(1);
        chk({7'h0, rx_rst}, 8'h00);
        host.fifo_ctl(8'h04, q);
        chk({7'h0, tx_rst}, 8'h01);
        tick(1);
        chk({7'h0, tx_rst}, 8'h00);
        rd(uic_pkg::ADDR_ISR, 8'hC1);
        host.fifo_ctl(8'h08, q);
        chk({7'h0, dma}, 8'h01);
        tick(2);
        chk({7'h0, rx_pin_n}, 8'h01);
        src.rx_count = 5'h01;
        tick(2);
        chk({7'h0, rx_pin_n}, 8'h00);
        chk({7'h0, tx_pin_n}, 8'h00);
        src.rx_count = 5'h00;
        wr(uic_pkg::ADDR_ISR, 8'h0E);
        chk({4'h0, fifo_en, dma, rx_rst, tx_rst}, 8'h04);
        rd(uic_pkg::ADDR_ISR, 8'h01);
    endtask

    // Every trigger code: raise at the level, drop just below it
    task automatic s_trig();
        int c;
        wr(uic_pkg::ADDR_IER, 8'h01);
        for (c = 0; c < 4; c++) begin
            host.fifo_ctl({c[1:0], 6'h00}, q);
            src.rx_count = lv[c] - 5'h01;
            tick(3);
            rd(uic_pkg::ADDR_ISR, 8'hC1);
            src.rx_count = lv[c];
            wait_irq(1'b1);
            rd(uic_pkg::ADDR_ISR, 8'hC4);
            src.rx_count = lv[c] - 5'h01;
            wait_irq(1'b0);
        end
        src.rx_count = 5'h00;
    endtask

    // Time-out: 4 x 10 + 12 = 52 bit times with one character held
    task automatic s_timeout();
        int i;
        src.rx_count = 5'h01;
        tick(2);
        for (i = 0; i < 53; i++) begin
            if (i == 50) chk({7'h0, irq_q}, 8'h00);
            bit_tick = 1'b1;
            tick(1);
            bit_tick = 1'b0;
            tick(1);
        end
        wait_irq(1'b1);
        rd(uic_pkg::ADDR_ISR, 8'hCC);
        rd(uic_pkg::ADDR_RHR, 8'h00);
        wait_irq(1'b0);
        src.rx_count = 5'h00;
        wr(uic_pkg::ADDR_IER, 8'h00);
    endtask

    // Pin drive for select/enable pairs 00, 01, 10; divisor bank hides
    task automatic s_pin_div();
        int i;
        for (i = 0; i < 3; i++) begin
            {int_sel, mcr_ie} = i[1:0];
            tick(2);
            chk({7'h0, irq_oe_q}, {7'h0, i != 0});
        end
        host.set_div(1'b1);
        wr(uic_pkg::ADDR_IER, 8'h0F);
        rd(uic_pkg::ADDR_IER, 8'h00);
        host.set_div(1'b0);
        rd(uic_pkg::ADDR_IER, 8'h00);
    endtask

    // Main sequence
    initial begin
        tick(5);
        srst = 1'b0;
        s_reset();
        s_tx();
        s_prio();
        s_fifo();
        s_trig();
        s_timeout();
        s_pin_div();
        test_done();
    end
endmodule
`default_nettype wire

// *** tb/uic_host_model.sv ***
// Host processor model driving the register bus of the control block.
// Assumes the bench calls its tasks; one strobe per call, 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module uic_host_model (
    // Clock
    input wire logic clk,
    // Register bus towards the block
    output var uic_pkg::uic_bus_t bus,
    output var logic divisor_access,
    // Read data back from the block
    input wire logic [7:0] rd_data_q
);
    // Idle bus at time zero
    initial begin
        bus = '0;
        divisor_access = 1'b0;
    end

    // Select data or divisor bank; only the data bank reaches the block
    task automatic set_div(input logic b);
        @(posedge clk);
        #1;
        divisor_access = b;
    endtask

    // One strobe, held over one edge, then released
    task automatic xfer(input logic w, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        bus.cs = 1'b1;
        bus.rd = ~w;
        bus.wr = w;
        bus.addr = a;
        bus.wdata = d;
        @(posedge clk);
        #1;
        q = rd_data_q;
        bus.cs = 1'b0;
        bus.rd = 1'b0;
        bus.wr = 1'b0;
        // Released lines show no stale value
        bus.addr = ~a;
        bus.wdata = ~d;
    endtask

    // Control writes always carry the enable bit, else they are lost
    task automatic fifo_ctl(input logic [7:0] d, output logic [7:0] q);
        xfer(1'b1, uic_pkg::ADDR_ISR, d | 8'h01, q);
    endtask
endmodule
`default_nettype wire
